// >>> smbc_bank_ctrl.v
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "smbc_regs.vh"

// Contract
// - Eight identical read/write bank control registers
// - Banks 0-6 reset widths 32,8,16,8,32,32,16
// - Bank 7 reset width from external strap
// - Reserved bits 31:22 and 15 read zero
// - Bit 21 clear holds burst advance high writes
// - Bit 20 clear holds address valid high writes
// - Write burst length 4, 8, reserved, continuous
// - Bit 17 selects synchronous writes
// - Bit 16 enables burst mode writes
// - Bit 14 enables eight word wrapping reads
// - Wrapping bursts for reads only, never writes
// - Bit 13 clear holds burst advance high reads
// - Bit 12 clear holds address valid high reads
// - Read burst length 4, 8, 16, continuous
module smbc_bank_ctrl (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire [1:0]  bank7_width_strap,
    input  wire        acc_start,
    input  wire [2:0]  acc_bank,
    input  wire        acc_write,
    input  wire        acc_busy,
    input  wire        seq_burst_adv,
    input  wire        seq_addr_valid,
    output reg         burst_advance_out,
    output reg         address_valid_out,
    output reg  [4:0]  acc_beats,
    output reg         acc_sync,
    output reg         acc_wrap,
    output reg  [1:0]  acc_width,
    output reg         acc_reserved
);

    // Register storage, one word per bank
    reg [31:0] bank_ctrl_reg [0:7];
    // Eight identical words, indexed by address bits 4:2
    // Bits 9:0 are kept as plain storage; only a few are decoded here
    // Reserved bits are dropped on write, so readback never shows them

    // Data phase bookkeeping for the bus
    reg        wr_pend_r;      // Write waiting for its data phase
    reg [2:0]  wr_idx_r;       // Bank addressed by that write

    // The strap pins are slow and asynchronous to the bus clock; three
    // stages are used so that a change is only believed once the last two
    // stages hold the same value, which filters a metastable first stage
    // Stage outputs below are internal and never leave the block
    // Strap synchroniser and settle counter
    reg [1:0]  strap_s1_r;     // First stage, read only by stage two
    reg [1:0]  strap_s2_r;
    reg [1:0]  strap_s3_r;
    reg [1:0]  strap_cnt_r;    // Cycles since reset release
    reg        strap_done_r;   // Bank 7 width captured

    // Configuration frozen at access start
    reg [31:0] cfg_r;
    reg        cfg_write_r;

    // Address phase decode
    wire       addr_phase;
    wire       in_range;
    wire [2:0] addr_idx;
    wire       wr_take;
    wire       rd_take;
    wire       strap_load;
    integer    i;

    // Address phase qualifiers
    // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready
    // Bit 1 of the transfer type separates NONSEQ and SEQ from IDLE and BUSY
    // Out-of-range addresses still answer, with zero data
    assign addr_phase = hsel & htrans[1] & hready;
    assign in_range   = (haddr[31:5] == 27'h0000000);
    assign addr_idx   = haddr[4:2];
    // Only whole-word writes update a register
    assign wr_take    = addr_phase & hwrite & in_range & (hsize == 3'h2);
    assign rd_take    = addr_phase & ~hwrite;
    // Capture once both late stages agree after the settle wait
    assign strap_load = ~strap_done_r & (strap_cnt_r == `SMBC_STRAP_WAIT) &
                        (strap_s2_r == strap_s3_r);

    // Banks 0 to 6 have fixed widths set at reset
    // Bank 7 has no fixed width of its own: the strap decides it
    // Until the strap lands it reads as the narrowest width, which is
    // the safe choice for a boot device of unknown width
    // Reset width of each bank; bank 7 starts narrow until strap lands
    function [1:0] reset_width;
        input [2:0] bank;
        begin
            case (bank)
                3'h0: reset_width = `SMBC_MW_32;
                3'h1: reset_width = `SMBC_MW_8;
                3'h2: reset_width = `SMBC_MW_16;
                3'h3: reset_width = `SMBC_MW_8;
                3'h4: reset_width = `SMBC_MW_32;
                3'h5: reset_width = `SMBC_MW_32;
                3'h6: reset_width = `SMBC_MW_16;
                default: reset_width = `SMBC_MW_8;
            endcase
        end
    endfunction

    // Write length 10 is reserved; the sequencer gets four beats and a flag
    // Continuous bursting needs a synchronous device, so an asynchronous
    // bank asking for it is limited to four beats instead
    // Code 11 maps to zero beats, read as continuous downstream
    // Burst length code to beat count; continuous only when synchronous
    function [4:0] blen_beats;
        input [1:0] code;
        input       sync;
        input       is_write;
        begin
            case (code)
                `SMBC_BLEN_4:   blen_beats = `SMBC_BEATS_4;
                `SMBC_BLEN_8:   blen_beats = `SMBC_BEATS_8;
                // Reserved for writes; fall back to the shortest burst
                `SMBC_BLEN_16:  blen_beats = is_write ? `SMBC_BEATS_4 : `SMBC_BEATS_16;
                `SMBC_BLEN_CONT: blen_beats = sync ? `SMBC_BEATS_CONT : `SMBC_BEATS_4;
                default:        blen_beats = `SMBC_BEATS_4;
            endcase
        end
    endfunction

    // Readback of a word with reserved bits cleared
    function [31:0] read_word;
        input [31:0] word;
        begin
            read_word = word & `SMBC_RW_MASK;
        end
    endfunction

    // No reset value matters here beyond a known start; the counter below
    // keeps the captured value from being used before the stages settle
    // Only stage two reads stage one
    // Strap synchroniser, three stages
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
            strap_s3_r <= 2'h0;
        end else begin
            strap_s1_r <= bank7_width_strap;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
        end
    end

    // The counter saturates at the settle count and then stays put
    // A strap still moving is caught later, once two stages agree
    // Capture happens after release, never while reset is held
    // Settle counter; the strap is caught after release, never in reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            if (strap_cnt_r != `SMBC_STRAP_WAIT) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            if (strap_load) begin
                strap_done_r <= 1'b1;
            end
        end
    end

    // Zero wait states: hready is always high, so the data phase of a
    // write always follows its address phase by exactly one cycle
    // The index is captured on every cycle with hready high; only the flag says
    // whether a store is due
    // hready is still honoured so the block can sit on a shared bus
    // Bus pipeline: remember the write until its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 3'h0;
        end else if (hready) begin
            wr_pend_r <= wr_take;
            wr_idx_r  <= addr_idx;
        end
    end

    // Writes land at the data phase edge; an access that starts at the
    // same edge still snapshots the old word
    // Non-word writes never reach this point: they are filtered in decode
    // Strap and software write in one cycle: software wins
    // Register file; the eight banks share one structure
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                bank_ctrl_reg[i] <= `SMBC_CTRL_RESET |
                                    ({30'h0, reset_width(i[2:0])} << `SMBC_MW_LO);
            end
        end else begin
            // Strap load first, so a software write in the same cycle wins
            if (strap_load) begin
                bank_ctrl_reg[7][`SMBC_MW_HI:`SMBC_MW_LO] <= strap_s3_r;
            end
            if (wr_pend_r) begin
                bank_ctrl_reg[wr_idx_r] <= hwdata & `SMBC_RW_MASK;
            end
        end
    end

    // Read data is registered at the address phase edge, so it stands
    // through the whole data phase and until the next read is taken
    // Forwarding covers a read issued right behind a write to the same bank
    // The strap case covers a read in the very cycle that bank 7 is loaded
    // Ready and response are flops with constant inputs
    // Unmapped and non-word accesses still answer OKAY
    // Bus answer; zero wait, write data forwarded to a following read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                if (!in_range) begin
                    // Unmapped reads answer zero, always OKAY
                    hrdata <= 32'h00000000;
                end else if (wr_pend_r && (wr_idx_r == addr_idx)) begin
                    // Word not yet stored; avoids returning stale data
                    hrdata <= read_word(hwdata);
                end else if (strap_load && (addr_idx == 3'h7)) begin
                    hrdata <= read_word({bank_ctrl_reg[7][31:6], strap_s3_r,
                                         bank_ctrl_reg[7][3:0]});
                end else begin
                    hrdata <= read_word(bank_ctrl_reg[addr_idx]);
                end
            end
        end
    end

    // The snapshot isolates a running access from software writes
    // Trade-off: a change waits for the next access, even a long burst
    // Direction is captured alongside so attributes decode consistently
    // Bank and direction are only trusted on the start pulse
    // Snapshot of the bank configuration at access start
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r       <= `SMBC_CTRL_RESET;
            cfg_write_r <= 1'b0;
        end else if (acc_start) begin
            // Stored value only; a write still in its data phase is too late
            cfg_r       <= bank_ctrl_reg[acc_bank];
            cfg_write_r <= acc_write;
        end
    end

    // Read sync and burst enables come from bits 9 and 8, outside the upper fields
    // Both beat counts are decoded every cycle; one is picked per direction
    // Width field shared by both directions
    // Decoded access attributes, derived from the snapshot
    wire       sync_w   = cfg_r[`SMBC_SYNC_WR_BIT];
    wire       sync_r   = cfg_r[`SMBC_SYNC_RD_BIT];
    wire       burst_w  = cfg_r[`SMBC_BURST_WR_BIT];
    wire       burst_r  = cfg_r[`SMBC_BURST_RD_BIT];
    wire [1:0] blen_w   = cfg_r[`SMBC_WR_BLEN_HI:`SMBC_WR_BLEN_LO];
    wire [1:0] blen_r   = cfg_r[`SMBC_RD_BLEN_HI:`SMBC_RD_BLEN_LO];
    wire [1:0] width    = cfg_r[`SMBC_MW_HI:`SMBC_MW_LO];
    wire [4:0] beats_rd = blen_beats(blen_r, sync_r, 1'b0);
    wire [4:0] beats_wr = blen_beats(blen_w, sync_w, 1'b1);

    // Any other length or width would wrap at the wrong word boundary,
    // so the enable bit alone is not enough
    // Both legal pairs move eight words per wrap
    // Wrap only on the two legal burst and width pairs
    wire wrap_ok = ((beats_rd == `SMBC_BEATS_16) && (width == `SMBC_MW_16)) ||
                   ((beats_rd == `SMBC_BEATS_8) && (width == `SMBC_MW_32));

    // Width follows the snapshot for reads and writes alike
    // The reserved flag lets the sequencer report a misprogrammed bank
    // Outputs hold after the access ends until the next start
    // Writes never wrap, whatever the read fields hold
    // Attribute outputs to the strobe sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_beats    <= `SMBC_BEATS_1;
            acc_sync     <= 1'b0;
            acc_wrap     <= 1'b0;
            acc_width    <= `SMBC_MW_8;
            acc_reserved <= 1'b0;
        end else begin
            acc_width <= width;
            if (cfg_write_r) begin
                // Single beats unless burst writes are enabled
                acc_beats    <= burst_w ? beats_wr : `SMBC_BEATS_1;
                acc_sync     <= sync_w;
                acc_wrap     <= 1'b0;
                acc_reserved <= burst_w & (blen_w == `SMBC_BLEN_16);
            end else begin
                acc_beats    <= burst_r ? beats_rd : `SMBC_BEATS_1;
                acc_sync     <= sync_r;
                acc_wrap     <= cfg_r[`SMBC_WRAP_RD_BIT] & burst_r & wrap_ok;
                acc_reserved <= 1'b0;
            end
        end
    end

    // Each strobe is passed through only while its enable bit is set
    // One cycle of delay is added by the output flop; the sequencer
    // must lead its raw strobes by a cycle to make up for it
    // Idle strobes are high so memories see no stray address
    // Strobe gating; both strobes idle high outside an access
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            burst_advance_out <= 1'b1;
            address_valid_out <= 1'b1;
        end else if (!acc_busy) begin
            burst_advance_out <= 1'b1;
            address_valid_out <= 1'b1;
        end else if (cfg_write_r) begin
            // Disabled strobe is held high for the whole write
            burst_advance_out <= cfg_r[`SMBC_BURST_ADV_WR_BIT] ?
                                 seq_burst_adv : 1'b1;
            address_valid_out <= cfg_r[`SMBC_ADDR_VAL_WR_BIT] ?
                                 seq_addr_valid : 1'b1;
        end else begin
            // Burst advance only means something on synchronous reads
            burst_advance_out <= (cfg_r[`SMBC_BURST_ADV_RD_BIT] & sync_r) ?
                                 seq_burst_adv : 1'b1;
            address_valid_out <= cfg_r[`SMBC_ADDR_VAL_RD_BIT] ?
                                 seq_addr_valid : 1'b1;
        end
    end

endmodule

// >>> smbc_regs.vh
`ifndef SMBC_REGS_VH
`define SMBC_REGS_VH

// Register map: eight bank control words, one aligned word each
`define SMBC_BANK_CTRL_BASE   8'h00
`define SMBC_BANK_CTRL_LAST   8'h1c
`define SMBC_NUM_BANKS        4'd8

// Bits that hold state; reserved bits 31:22 and 15 read as zero
`define SMBC_RW_MASK          32'h003f7fff

// Field positions inside a bank control word
`define SMBC_BURST_ADV_WR_BIT 21
`define SMBC_ADDR_VAL_WR_BIT  20
`define SMBC_WR_BLEN_HI       19
`define SMBC_WR_BLEN_LO       18
`define SMBC_SYNC_WR_BIT      17
`define SMBC_BURST_WR_BIT     16
`define SMBC_WRAP_RD_BIT      14
`define SMBC_BURST_ADV_RD_BIT 13
`define SMBC_ADDR_VAL_RD_BIT  12
`define SMBC_RD_BLEN_HI       11
`define SMBC_RD_BLEN_LO       10
`define SMBC_SYNC_RD_BIT      9
`define SMBC_BURST_RD_BIT     8
`define SMBC_MW_HI            5
`define SMBC_MW_LO            4

// Reset value of the upper fields, width field added per bank
`define SMBC_CTRL_RESET       32'h00303000

// Memory width encodings
`define SMBC_MW_8             2'h0
`define SMBC_MW_16            2'h1
`define SMBC_MW_32            2'h2

// Burst length encodings
`define SMBC_BLEN_4           2'h0
`define SMBC_BLEN_8           2'h1
`define SMBC_BLEN_16          2'h2
`define SMBC_BLEN_CONT        2'h3

// Beat counts driven to the sequencer, zero means continuous
`define SMBC_BEATS_1          5'h01
`define SMBC_BEATS_4          5'h04
`define SMBC_BEATS_8          5'h08
`define SMBC_BEATS_16         5'h10
`define SMBC_BEATS_CONT       5'h00

// Strap settle count after reset release
`define SMBC_STRAP_WAIT       2'h2

`endif

// >>> smbc_bank_ctrl_checker.sv
`timescale 1ns/1ps
// Port-level watch over the bank control block
module smbc_bank_ctrl_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        hresp,
    input wire        acc_start,
    input wire        acc_write,
    input wire        acc_busy,
    input wire        seq_burst_adv,
    input wire        seq_addr_valid,
    input wire        burst_advance_out,
    input wire        address_valid_out,
    input wire [4:0]  acc_beats,
    input wire        acc_wrap,
    input wire        acc_reserved
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero-wait slave, never an error response
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or error response");
    // Reads beyond the eight banks return zero
    a_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite
        && haddr >= 32'h20 |=> hrdata == 32'h0) else $error("unmapped read not zero");
    // Reserved bits never leak out
    a_resv_zero: assert property (hrdata[31:22] == 10'h0 && !hrdata[15])
        else $error("reserved bits set in read data");
    // Strobes idle high outside an access
    a_ba_idle: assert property (!$past(acc_busy) |-> burst_advance_out)
        else $error("burst advance active while idle");
    a_av_idle: assert property (!$past(acc_busy) |-> address_valid_out)
        else $error("address valid active while idle");
    // A low strobe must come from the sequencer one cycle earlier
    a_ba_follow: assert property (!burst_advance_out |-> !$past(seq_burst_adv))
        else $error("burst advance low without cause");
    a_av_follow: assert property (!address_valid_out |-> !$past(seq_addr_valid))
        else $error("address valid low without cause");
    // Reserved write length falls back to four beats
    a_resv_len: assert property (acc_reserved |-> acc_beats == 5'h04 && !acc_wrap)
        else $error("reserved length not shown as four beats");
    // Writes never wrap
    a_wrap_rd_only: assert property (acc_start && acc_write |-> ##2 !acc_wrap)
        else $error("wrapping burst on a write");
    // Attributes move only after a fresh start
    a_snap_stable: assert property (!$past(acc_start) && !$past(acc_start, 2)
        |-> $stable(acc_beats) && $stable(acc_wrap)) else $error("attributes changed mid access");
endmodule
bind smbc_bank_ctrl smbc_bank_ctrl_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .acc_start(acc_start), .acc_write(acc_write), .acc_busy(acc_busy),
    .seq_burst_adv(seq_burst_adv), .seq_addr_valid(seq_addr_valid),
    .burst_advance_out(burst_advance_out), .address_valid_out(address_valid_out),
    .acc_beats(acc_beats), .acc_wrap(acc_wrap), .acc_reserved(acc_reserved)
);

// >>> smbc_seq_model.sv
`timescale 1ns/1ps
// Memory-side sequencer: one start pulse, then a fixed busy stretch
module smbc_seq_model (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        go,
    input  wire        wr_in,
    output logic       acc_start,
    output logic [2:0] acc_bank,
    output logic       acc_write,
    output logic       acc_busy,
    output logic       seq_burst_adv,
    output logic       seq_addr_valid
);
    logic [2:0] busy_cnt_r; // Remaining busy cycles
    logic       busy_nxt;   // Busy in the coming cycle
    assign busy_nxt = acc_start || busy_cnt_r > 3'h1;
    // Outside a start, bank and direction wander so stale values are not trusted
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_start      <= 1'b0;
            acc_bank       <= 3'h0;
            acc_write      <= 1'b0;
            acc_busy       <= 1'b0;
            busy_cnt_r     <= 3'h0;
            seq_burst_adv  <= 1'b1;
            seq_addr_valid <= 1'b1;
        end else begin
            acc_start      <= go;
            acc_bank       <= go ? 3'h2 : ~acc_bank;
            acc_write      <= go ? wr_in : ~acc_write;
            busy_cnt_r     <= acc_start ? 3'h6 : busy_cnt_r - {2'h0, busy_cnt_r != 3'h0};
            acc_busy       <= busy_nxt;
            // Strobes low while busy, toggling when idle
            seq_burst_adv  <= busy_nxt ? 1'b0 : ~seq_burst_adv;
            seq_addr_valid <= busy_nxt ? 1'b0 : ~seq_addr_valid;
        end
    end
endmodule

// >>> smbc_tb.sv
`timescale 1ns/1ps
`include "smbc_regs.vh"
module tb;
    logic        hclk, hresetn, hsel, hwrite, go, wr_in;
    logic [1:0]  htrans, strap;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, rd;
    wire         hreadyout, hresp, acc_start, acc_write, acc_busy, sba, sav;
    wire         bao, avo, acc_sync, acc_wrap, acc_res;
    wire  [31:0] hrdata;
    wire  [4:0]  acc_beats;
    wire  [2:0]  acc_bank;
    wire  [1:0]  acc_width;
    int          n_mismatch, samples_checked, i;
    // Reset width per bank, bank 7 from the strap value below
    logic [1:0]  wdt [8] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1};
    // Config, write flag, expected {ba, av, res, width, wrap, sync, beats}
    logic [44:0] tab [13] = '{{32'h00004510, 1'b0, 12'hc88}, {32'h00004920, 1'b0, 12'hd10},
        {32'h00004910, 1'b0, 12'hcd0}, {32'h00004520, 1'b0, 12'hd48},
        {32'h00003f00, 1'b0, 12'h020}, {32'h00001c00, 1'b0, 12'h801},
        {32'h00374520, 1'b1, 12'h128}, {32'h00190000, 1'b1, 12'ha04},
        {32'h000f0000, 1'b1, 12'hc20}, {32'h000c0000, 1'b1, 12'hc01},
        {32'h000d0000, 1'b1, 12'hc04}, {32'h00210000, 1'b1, 12'h404},
        {32'h00002100, 1'b0, 12'hc04}};
    smbc_bank_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bank7_width_strap(strap),
        .acc_start(acc_start), .acc_bank(acc_bank), .acc_write(acc_write), .acc_busy(acc_busy),
        .seq_burst_adv(sba), .seq_addr_valid(sav), .burst_advance_out(bao),
        .address_valid_out(avo), .acc_beats(acc_beats), .acc_sync(acc_sync),
        .acc_wrap(acc_wrap), .acc_width(acc_width), .acc_reserved(acc_res));
    smbc_seq_model u_seq (.hclk(hclk), .hresetn(hresetn), .go(go), .wr_in(wr_in),
        .acc_start(acc_start), .acc_bank(acc_bank), .acc_write(acc_write),
        .acc_busy(acc_busy), .seq_burst_adv(sba), .seq_addr_valid(sav));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; each phase held until hready is seen high
    task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] r);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        r = hrdata;
        if (k >= 100) begin n_mismatch++; report_and_stop; end
    endtask
    // Bounded wait for the sequencer's busy level
    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        do begin @(posedge hclk); #1; k++; end while (acc_busy !== lvl && k < 20);
        if (k >= 20) begin n_mismatch++; report_and_stop; end
    endtask
    initial begin
        #300000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        {hresetn, hsel, hwrite, go, wr_in, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        strap = 2'b01;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            ahb_xfer(32'(i * 4), 1'b0, 32'h0, rd);
            chk(rd, `SMBC_CTRL_RESET | {26'h0, wdt[i], 4'h0});
        end
        for (i = 0; i < 8; i++) ahb_xfer(32'(i * 4), 1'b1, ~32'(i << 4) & `SMBC_RW_MASK, rd);
        for (i = 0; i < 8; i++) begin
            ahb_xfer(32'(i * 4), 1'b0, 32'h0, rd);
            chk(rd, ~32'(i << 4) & `SMBC_RW_MASK);
        end
        ahb_xfer(32'h20, 1'b1, 32'h5a5a5a5a, rd);
        ahb_xfer(32'h20, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        // Each case: program bank 2, run one access, check attributes and strobes
        for (i = 0; i < 13; i++) begin
            ahb_xfer(32'h08, 1'b1, tab[i][44:13], rd);
            if (i > 0) chk({27'h0, acc_beats}, {27'h0, tab[i - 1][4:0]});
            @(posedge hclk);
            go <= 1'b1;
            wr_in <= tab[i][12];
            @(posedge hclk);
            go <= 1'b0;
            wait_busy(1'b1);
            @(posedge hclk);
            #1;
            chk({20'h0, bao, avo, acc_res, acc_width, acc_wrap, acc_sync, acc_beats},
                {20'h0, tab[i][11:0]});
            wait_busy(1'b0);
            @(posedge hclk);
            #1;
            chk({30'h0, bao, avo}, 32'h3);
        end
        // Second reset with a 32-bit strap clears earlier writes
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= 2'b10;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        ahb_xfer(32'h1c, 1'b0, 32'h0, rd);
        chk(rd, 32'h00303020);
        ahb_xfer(32'h04, 1'b0, 32'h0, rd);
        chk(rd, 32'h00303000);
        report_and_stop;
    end
endmodule
